// file: crs_board.sv
/* Board model: external reset source and strap resistors.
   The bench supplies the reference clock on pclk. */
`timescale 1ns/1ps
module crs_board (pclk, reset_ext_n, clock_ratio_straps);
    input wire logic pclk;
    output logic reset_ext_n = 1'b0;
    output logic [1:0] clock_ratio_straps = 2'h0;
    // Straps move only inside reset and stay put after
    task pulse(input logic [1:0] s, input int n);
        @(posedge pclk);
        reset_ext_n <= 1'b0;
        clock_ratio_straps <= s;
        repeat (n) @(posedge pclk);
        reset_ext_n <= 1'b1;
    endtask
endmodule

// file: crs_divider.sv
/*
 Programmable divider: emits a one-cycle enable every div cycles of the core
 enable, and a bit clock toggling with half the period. Assumes div >= 2.
*/
`timescale 1ns/1ps
module crs_divider #(
    parameter int W = 16
) (
    pclk,
    presetn,
    tick_in,
    div,
    tick_out,
    bit_clk
);
    input wire logic pclk;
    input wire logic presetn;
    input wire logic tick_in;
    input wire logic [W-1:0] div;
    output logic tick_out;
    output logic bit_clk;

    typedef struct packed {
        logic [W-1:0] cnt;
        logic tick;
        logic clk;
    } crs_div_st_t;

    crs_div_st_t s_r, s_nxt;

    always_comb begin
        s_nxt = s_r;
        s_nxt.tick = 1'b0;
        if (tick_in) begin
            if (s_r.cnt >= div - W'(1) || div < W'(2)) begin
                s_nxt.cnt = '0;
                s_nxt.tick = 1'b1;
                s_nxt.clk = 1'b0;
            end else begin
                s_nxt.cnt = s_r.cnt + W'(1);
                if (s_r.cnt == (div >> 1) - W'(1)) begin
                    s_nxt.clk = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign tick_out = s_r.tick;
    assign bit_clk = s_r.clk;
endmodule

// file: crs_pkg.sv
/*
 Package for the clock and reset sequencer: register map, field positions,
 reset values and timing counts. Assumes a 50 MHz pclk.
*/
package crs_pkg;
    localparam int CLK_MHZ = 50;
    localparam logic [7:0] OFF_PWR_CTL = 8'h00;
    localparam logic [7:0] OFF_SPORT_DIV = 8'h04;
    localparam logic [7:0] OFF_SPI_DIV = 8'h08;
    localparam logic [7:0] OFF_STATUS = 8'h0c;
    localparam int PLL_MUL_LSB = 0;
    localparam int PLL_MUL_W = 5;
    localparam int PLL_OVR_BIT = 8;
    localparam int DIV_W = 16;
    localparam int HOLD_CYCLES = 4096;
    localparam int HOLD_CYCLES_MAX = 4097;
    localparam int PLL_LOCK_US = 100;
    localparam int PLL_LOCK_CYC = PLL_LOCK_US * CLK_MHZ;
    localparam int CORE_CLOCK_MIN_PS = 6660;
    localparam int CORE_CLOCK_MAX_PS = 10000;
    localparam logic [31:0] PWR_CTL_RST = 32'h0000_0000;
    localparam logic [DIV_W-1:0] DIV_RST = 16'h0004;
    localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;
endpackage

// file: crs_sequencer.sv
/*
 Clock and reset sequencer top. pclk stands for the reference clock input;
 the core clock is modelled as a multiplier code plus a core tick enable.
 Assumes the board holds straps stable before releasing reset.
*/
// Chosen here: the register addresses and register access over APB.
// How it works
// - one core clock times all internal logic; here only the dividers run on core_tick, the reset and register logic on pclk
// - straps select multiplier during reset
// - serial bit period is core times divider
// - SPI bit period is core times divider
// - ratios 3,8,16 plus software override
// - software ratio keeps core period legal
// - core reset held 4096 cycles after release
// - late release may add one cycle
// - PLL lock within reset low time
`timescale 1ns/1ps
module crs_sequencer
    import crs_pkg::*;
#(
    parameter int HOLD = crs_pkg::HOLD_CYCLES,
    parameter int REF_PS = 20000,
    parameter logic [4:0] MUL_CODE0 = 5'd3,
    parameter logic [4:0] MUL_CODE1 = 5'd16,
    parameter logic [4:0] MUL_CODE2 = 5'd8,
    parameter logic [4:0] MUL_CODE3 = 5'd3
) (
    pclk,
    presetn,
    reset_ext_n,
    clock_ratio_straps,
    psel,
    penable,
    pwrite,
    paddr,
    pwdata,
    prdata,
    pready,
    pslverr,
    core_reset_n,
    core_mul,
    core_tick,
    sport_tick,
    sport_bit_clk,
    spi_tick,
    spi_bit_clk
);
    import crs_pkg::*;
    input wire logic pclk;
    input wire logic presetn;
    input wire logic reset_ext_n;
    input wire logic [1:0] clock_ratio_straps;
    input wire logic psel;
    input wire logic penable;
    input wire logic pwrite;
    input wire logic [7:0] paddr;
    input wire logic [31:0] pwdata;
    output logic [31:0] prdata;
    output logic pready;
    output logic pslverr;
    output logic core_reset_n;
    output logic [4:0] core_mul;
    output logic core_tick;
    output logic sport_tick;
    output logic sport_bit_clk;
    output logic spi_tick;
    output logic spi_bit_clk;

    typedef struct packed {
        logic [1:0] rst_sync;
        logic [1:0] strap_s1;
        logic [1:0] strap_s2;
        logic [4:0] strap_mul;
        logic [12:0] hold_cnt;
        logic core_rst_n;
        logic [31:0] pwr_ctl;
        logic [DIV_W-1:0] sport_div;
        logic [DIV_W-1:0] spi_div;
        logic [31:0] rdata;
        logic err;
        logic reject;
    } crs_st_t;

    crs_st_t s_r, s_nxt;
    logic ext_rst_n;
    logic [4:0] strap_map;
    logic [4:0] wr_mul;
    logic setup;

    assign ext_rst_n = s_r.rst_sync[1];
    assign setup = psel && !penable;
    assign wr_mul = pwdata[PLL_MUL_LSB +: PLL_MUL_W];

    always_comb begin
        case (s_r.strap_s2)
            2'b00: strap_map = MUL_CODE0;
            2'b01: strap_map = MUL_CODE1;
            2'b10: strap_map = MUL_CODE2;
            default: strap_map = MUL_CODE3;
        endcase
    end

    always_comb begin
        s_nxt = s_r;
        s_nxt.rst_sync = {s_r.rst_sync[0], reset_ext_n};
        s_nxt.strap_s1 = clock_ratio_straps;
        s_nxt.strap_s2 = s_r.strap_s1;
        if (!ext_rst_n) begin
            s_nxt.strap_mul = strap_map;
            s_nxt.hold_cnt = '0;
            s_nxt.core_rst_n = 1'b0;
            s_nxt.pwr_ctl = PWR_CTL_RST;
        end else if (!s_r.core_rst_n) begin
            // Counted on the synchronised release so the end is glitch-free
            if (s_r.hold_cnt == 13'(HOLD - 1)) begin
                s_nxt.core_rst_n = 1'b1;
            end else begin
                s_nxt.hold_cnt = s_r.hold_cnt + 13'd1;
            end
        end
        if (setup) begin
            s_nxt.err = 1'b0;
            s_nxt.reject = 1'b0;
            s_nxt.rdata = UNMAPPED_DATA;
            case (paddr)
                OFF_PWR_CTL: s_nxt.rdata = s_r.pwr_ctl;
                OFF_SPORT_DIV: s_nxt.rdata = 32'(s_r.sport_div);
                OFF_SPI_DIV: s_nxt.rdata = 32'(s_r.spi_div);
                OFF_STATUS: s_nxt.rdata = {13'h0000, s_r.hold_cnt, s_r.core_rst_n, s_r.strap_mul};
                default: s_nxt.err = 1'b1;
            endcase
            // Reject ratios whose core period leaves the legal window
            if (pwrite && paddr == OFF_PWR_CTL && pwdata[PLL_OVR_BIT] &&
                (wr_mul == 5'd0 || int'(REF_PS) > int'(wr_mul) * CORE_CLOCK_MAX_PS ||
                 int'(REF_PS) < int'(wr_mul) * CORE_CLOCK_MIN_PS)) begin
                s_nxt.reject = 1'b1;
                s_nxt.err = 1'b1;
            end
        end
        if (psel && penable && pwrite && !s_r.err) begin
            case (paddr)
                OFF_PWR_CTL: s_nxt.pwr_ctl = pwdata;
                OFF_SPORT_DIV: s_nxt.sport_div = pwdata[DIV_W-1:0];
                OFF_SPI_DIV: s_nxt.spi_div = pwdata[DIV_W-1:0];
                default: s_nxt.err = s_r.err;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r <= '{
                rst_sync: 2'b00,
                strap_s1: 2'b00,
                strap_s2: 2'b00,
                strap_mul: 5'h00,
                hold_cnt: 13'h0000,
                core_rst_n: 1'b0,
                pwr_ctl: PWR_CTL_RST,
                sport_div: DIV_RST,
                spi_div: DIV_RST,
                rdata: 32'h0000_0000,
                err: 1'b0,
                reject: 1'b0
            };
        end else begin
            s_r <= s_nxt;
        end
    end

    // Software override wins over the strap ratio
    assign core_mul = s_r.pwr_ctl[PLL_OVR_BIT] ? s_r.pwr_ctl[PLL_MUL_LSB +: PLL_MUL_W] : s_r.strap_mul;
    assign core_reset_n = s_r.core_rst_n;
    assign core_tick = s_r.core_rst_n;
    assign pready = 1'b1;
    assign prdata = s_r.rdata;
    assign pslverr = psel && penable && s_r.err;

    logic [1:0] ch_tick;
    logic [1:0] ch_clk;
    logic [DIV_W-1:0] ch_div [2];

    assign ch_div[0] = s_r.sport_div;
    assign ch_div[1] = s_r.spi_div;

    // One divider per bit-clock channel: 0 serial, 1 SPI
    for (genvar g = 0; g < 2; g++) begin : g_div
        crs_divider #(.W(DIV_W)) u_div (
            .pclk(pclk),
            .presetn(presetn),
            .tick_in(core_tick),
            .div(ch_div[g]),
            .tick_out(ch_tick[g]),
            .bit_clk(ch_clk[g])
        );
    end

    assign sport_tick = ch_tick[0];
    assign sport_bit_clk = ch_clk[0];
    assign spi_tick = ch_tick[1];
    assign spi_bit_clk = ch_clk[1];
endmodule

// file: crs_sequencer_asserts.sv
/* Port assertions for the clock and reset sequencer.
   Bound from the bench; HOLD follows the bound instance. */
`timescale 1ns/1ps
module crs_chk #(parameter int HOLD = 4096) (pclk, presetn, reset_ext_n, psel, penable, pwrite, paddr, pwdata,
    prdata, pslverr, core_reset_n, core_mul, core_tick, sport_tick, spi_tick);
    input wire logic pclk, presetn, reset_ext_n, psel, penable, pwrite, pslverr;
    input wire logic core_reset_n, core_tick, sport_tick, spi_tick;
    input wire logic [7:0] paddr;
    input wire logic [31:0] pwdata, prdata;
    input wire logic [4:0] core_mul;
    int cnt;
    // Hold cycles since release; slack covers sync latency
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt <= 0;
        end else begin
            cnt <= (reset_ext_n && !core_reset_n) ? cnt + 1 : 0;
        end
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence pm_wr;
        psel && penable && pwrite && paddr == 8'h00;
    endsequence
    hold_exact_a: assert property ($rose(core_reset_n) |-> cnt >= HOLD && cnt <= HOLD + 3)
        else $error("hold length");
    hold_cap_a: assert property (!core_reset_n |-> cnt <= HOLD + 3) else $error("hold too long");
    ext_low_a: assert property (!reset_ext_n [*3] |=> !core_reset_n) else $error("core left running");
    tick_on_a: assert property (core_reset_n |-> core_tick) else $error("no core tick");
    unmapped_a: assert property (psel && penable && paddr > 8'h0c |-> pslverr) else $error("no error");
    ovr_reject_a: assert property (pm_wr ##0 pwdata[8] && !(pwdata[4:0] inside {5'd2, 5'd3}) |-> pslverr)
        else $error("bad ratio taken");
    ovr_apply_a: assert property (pm_wr ##0 pwdata[8] && !pslverr |=> core_mul == $past(pwdata[4:0]))
        else $error("ratio not applied");
    ovr_keep_a: assert property (pm_wr ##0 pslverr |=> $stable(core_mul)) else $error("ratio moved");
    strap_ratio_a: assert property ($rose(core_reset_n) |-> core_mul inside {5'd3, 5'd8, 5'd16})
        else $error("strap ratio");
    sport_gap_a: assert property (sport_tick |=> !sport_tick) else $error("serial tick");
    spi_gap_a: assert property (spi_tick |=> !spi_tick) else $error("spi tick");
endmodule

// file: tb_clock_reset_sequencer.sv
/* Self-checking bench for the sequencer with board model.
   Short HOLD keeps the run brief. */
`timescale 1ns/1ps
module tb_clock_reset_sequencer;
    import crs_pkg::*;
    localparam int HD = 16;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, er, pready, pslverr;
    logic reset_ext_n, core_reset_n, core_tick, sport_tick, spi_tick;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, rd, prdata;
    logic [1:0] clock_ratio_straps;
    logic [4:0] core_mul;
    int n_mismatch = 0, num_checks = 0, n, d, mulq[4] = '{3, 16, 8, 3};
    crs_board board_u(.pclk(pclk), .reset_ext_n(reset_ext_n), .clock_ratio_straps(clock_ratio_straps));
    crs_sequencer #(.HOLD(HD)) dut_u(.pclk(pclk), .presetn(presetn), .reset_ext_n(reset_ext_n),
        .clock_ratio_straps(clock_ratio_straps), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .core_reset_n(core_reset_n),
        .core_mul(core_mul), .core_tick(core_tick), .sport_tick(sport_tick), .sport_bit_clk(), .spi_tick(spi_tick),
        .spi_bit_clk());
    initial begin
        forever #10 pclk = ~pclk;
    end
    task chk(input string s, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("ERROR %s exp %h got %h", s, e, g);
        end
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] v);
        @(posedge pclk);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= v;
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    task boot(input logic [1:0] s, input int low);
        board_u.pulse(s, low);
        n = 0;
        while (core_reset_n !== 1'b1 && n < 99) begin
            @(posedge pclk) #1;
            n++;
        end
        chk("hold", 1, n >= HD + 1 && n <= HD + 4);
        chk("mul", mulq[s], core_mul);
        chk("tick", 1, core_tick);
    endtask
    task wrap_up;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        void'($urandom(32'hc3968273));
        repeat (8) @(posedge pclk);
        presetn <= 1;
        boot(2'h0, 5000);
        d = $urandom % 4;
        for (int i = 0; i < 4; i++) boot(2'(i ^ d), 1000);
        $display("test straps done");
        for (int i = 1; i < 3; i++) begin
            apb(0, 8'(4 * i), 0);
            chk("div reset", 32'(DIV_RST), rd);
            d = 4 + $urandom % 8;
            apb(1, 8'(4 * i), d);
            for (int k = 0; k < 3; k++) begin
                n = 0;
                do @(posedge pclk) #1; while ((i == 1 ? sport_tick : spi_tick) !== 1'b1 && ++n < 99);
            end
            chk("period", d, n + 1);
        end
        $display("test dividers done");
        for (int i = 0; i < 3; i++) begin
            d = i == 0 ? 2 : i == 1 ? 0 : 4 + $urandom % 28;
            apb(1, OFF_PWR_CTL, 32'h100 | d);
            chk("refuse", i != 0, er);
            apb(0, OFF_PWR_CTL, 0);
            chk("pwr ctl", 32'h102, rd);
        end
        chk("ovr mul", 2, core_mul);
        apb(0, 8'h10 + 8'(4 * ($urandom % 60)), 0);
        chk("unmapped", 1, er);
        chk("unmapped data", UNMAPPED_DATA, rd);
        boot(clock_ratio_straps, 4);
        $display("test software ratio done");
        wrap_up;
    end
    initial begin
        repeat (40000) @(posedge pclk);
        n_mismatch++;
        wrap_up;
    end
endmodule
bind crs_sequencer crs_chk #(.HOLD(HOLD)) chk_u(.*);
